// file: hdl/tsl_pkg.sv
package tsl_pkg;

	// Register offsets on the plain register port.
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_SEL = 4'h1;
	localparam logic [3:0] ADDR_STAT = 4'h2;

	// Control register fields.
	localparam int CTRL_READER_AUTO = 0;
	localparam int CTRL_FULL_DUPLEX = 1;
	localparam int CTRL_NO_ANSWER = 2;
	localparam int CTRL_ANSWERBACK = 3;
	localparam int CTRL_PUNCH_EN = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Selection lamps: a set bit is a lit lamp, which means local operation.
	localparam int SEL_KBD = 0;
	localparam int SEL_READER = 1;
	localparam int SEL_PRINTER = 2;
	localparam int SEL_PUNCH = 3;
	localparam logic [7:0] SEL_RESET = 8'h00;

	// Status register fields.
	localparam int STAT_SEND_EN = 0;
	localparam int STAT_INTR_HALT = 1;
	localparam int STAT_READER_RUN = 2;
	localparam int STAT_TAPE_PUNCH_ENABLE = 3;
	localparam int STAT_PRIMED = 4;
	localparam int STAT_DTR = 5;
	localparam int STAT_CTS = 6;
	localparam int STAT_DSR = 7;

	// Transmitter indices.
	localparam int TX_KBD = 0;
	localparam int TX_READER = 1;

	// Control characters recognised on the line.
	localparam logic [7:0] CH_EOT = 8'h04;
	localparam logic [7:0] CH_ACK = 8'h06;
	localparam logic [7:0] CH_DC1 = 8'h11;
	localparam logic [7:0] CH_DC2 = 8'h12;
	localparam logic [7:0] CH_DC3 = 8'h13;
	localparam logic [7:0] CH_DC4 = 8'h14;
	localparam logic [7:0] CH_NAK = 8'h15;

	// Timing.
	localparam int CLK_HZ = 25_000_000;
	localparam int DTR_OFF_MS = 100;
	localparam int DTR_OFF_CYCLES = CLK_HZ / 1000 * DTR_OFF_MS;
	localparam int TMR_W = 22;

	typedef enum logic [1:0] {S_IDLE, S_GRANT, S_PRESENT} tsl_send_t;

endpackage

// file: hdl/tsl_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tsl_tmr_if;
	logic start;
	logic busy;
	modport ctl (output start, input busy);
	modport tmr (input start, output busy);
endinterface
`default_nettype wire

// file: hdl/tsl_pulse_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tsl_pulse_timer
	import tsl_pkg::*;
#(
	parameter int unsigned CYCLES = DTR_OFF_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	tsl_tmr_if.tmr tmr
);

	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic busy;
	} tsl_tmr_state_t;

	tsl_tmr_state_t q_reg;
	tsl_tmr_state_t q_next;

	// A start during a running pulse restarts it, so back-to-back EOTs
	// stretch the pulse rather than chopping it.
	always_comb begin
		q_next = q_reg;
		if (tmr.start) begin
			q_next.busy = 1'h1;
			q_next.cnt = TMR_W'(CYCLES - 1);
		end else if (q_reg.busy) begin
			if (q_reg.cnt == '0) begin
				q_next.busy = 1'h0;
			end else begin
				q_next.cnt = q_reg.cnt - TMR_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign tmr.busy = q_reg.busy;

endmodule
`default_nettype wire

// file: hdl/tsl_send_line.sv
`timescale 1ns/1ps
`default_nettype none
module tsl_send_line
	import tsl_pkg::*;
#(
	parameter int unsigned DTR_OFF_LEN = DTR_OFF_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	input wire logic [1:0] msgAvail,
	input wire logic [1:0] sendReady,
	input wire logic [1:0] charAvail,
	input wire logic [1:0][7:0] txData,
	output logic [1:0] sendMsg,
	output logic [1:0] presentChar,
	input wire logic tabBusy,
	input wire logic locDistReady,
	input wire logic lineDistReady,
	output logic [7:0] locTxData,
	output logic locTxStrobe,
	output logic [7:0] lineTxData,
	output logic lineTxStrobe,
	input wire logic [7:0] lineRxData,
	input wire logic lineRxStrobe,
	output logic [7:0] printerData,
	output logic printerStrobe,
	output logic [7:0] punchData,
	output logic punchStrobe,
	output logic readerRun,
	output logic tapePunchEnable,
	input wire logic sendEnableButton,
	input wire logic intrRx,
	input wire logic alarm,
	input wire logic ringInd,
	input wire logic dataSetReady,
	input wire logic clearToSend,
	output logic dataTermReady,
	output logic requestToSend,
	output logic answerBackStart,
	output logic sendEnableLamp
);

	typedef struct packed {
		tsl_send_t st;
		logic txSel;
		logic [7:0] ctrl;
		logic [7:0] sel;
		logic sendEn;
		logic intrHalt;
		logic readerRun;
		logic punchOn;
		logic primed;
		logic ctsPrev;
		logic abStart;
		logic [7:0] rdata;
		logic [7:0] locData;
		logic locStb;
		logic [7:0] lineData;
		logic lineStb;
		logic [7:0] prtData;
		logic prtStb;
		logic [7:0] pchData;
		logic pchStb;
	} tsl_main_state_t;

	tsl_main_state_t q_reg;
	tsl_main_state_t q_next;
	tsl_tmr_if tmrIf ();

	logic txLocal;
	logic distReady;
	logic presentOk;
	logic charTaken;
	logic eotEvt;
	logic ctsRise;
	logic [1:0] msgOk;
	logic [7:0] stat;
	logic [7:0] rxByte;

	tsl_pulse_timer #(
		.CYCLES(DTR_OFF_LEN)
	) u_dtr_timer (
		.clk(clk),
		.nrst(nrst),
		.tmr(tmrIf.tmr)
	);

	assign rxByte = lineRxData;
	assign txLocal = q_reg.txSel ? q_reg.sel[SEL_READER] : q_reg.sel[SEL_KBD];
	assign distReady = txLocal ? locDistReady : lineDistReady;
	assign presentOk = sendReady[q_reg.txSel] && !tabBusy && distReady;
	assign charTaken = (q_reg.st == S_PRESENT) && charAvail[q_reg.txSel];
	assign ctsRise = clearToSend && !q_reg.ctsPrev;

	// A keyboard on line waits for send-enable; the reader on line waits for
	// clear to send and, under remote control, for the reader to be started.
	assign msgOk[TX_KBD] = msgAvail[TX_KBD] && (q_reg.sel[SEL_KBD] || q_reg.sendEn);
	assign msgOk[TX_READER] = msgAvail[TX_READER] && (q_reg.sel[SEL_READER]
		|| (clearToSend && !tmrIf.busy
		&& (!q_reg.ctrl[CTRL_READER_AUTO] || q_reg.readerRun)));

	always_comb begin
		stat = '0;
		stat[STAT_SEND_EN] = q_reg.sendEn;
		stat[STAT_INTR_HALT] = q_reg.intrHalt;
		stat[STAT_READER_RUN] = q_reg.readerRun;
		stat[STAT_TAPE_PUNCH_ENABLE] = q_reg.punchOn;
		stat[STAT_PRIMED] = q_reg.primed;
		stat[STAT_DTR] = dataTermReady;
		stat[STAT_CTS] = clearToSend;
		stat[STAT_DSR] = dataSetReady;
	end

	always_comb begin
		q_next = q_reg;
		q_next.abStart = 1'h0;
		q_next.locStb = 1'h0;
		q_next.lineStb = 1'h0;
		q_next.prtStb = 1'h0;
		q_next.pchStb = 1'h0;
		q_next.ctsPrev = clearToSend;
		eotEvt = 1'h0;

		// Only one transmitter may hold the distributor at a time.
		case (q_reg.st)
			S_IDLE: begin
				if (msgOk[TX_KBD]) begin
					q_next.st = S_GRANT;
					q_next.txSel = 1'h0;
				end else if (msgOk[TX_READER]) begin
					q_next.st = S_GRANT;
					q_next.txSel = 1'h1;
				end
			end
			S_GRANT: begin
				if (!msgOk[q_reg.txSel]) begin
					q_next.st = S_IDLE;
				end else if (presentOk) begin
					q_next.st = S_PRESENT;
				end
			end
			S_PRESENT: begin
				if (charTaken) begin
					q_next.st = S_GRANT;
					if (txLocal) begin
						q_next.locData = txData[q_reg.txSel];
						q_next.locStb = 1'h1;
					end else begin
						q_next.lineData = txData[q_reg.txSel];
						q_next.lineStb = 1'h1;
						eotEvt = txData[q_reg.txSel] == CH_EOT;
					end
				end
			end
			default: begin
				q_next.st = S_IDLE;
			end
		endcase

		// Local receivers take the local distributor; the printer looks at no receiver
		// status, the punch only at tape punch enable; line receivers take the line copy.
		if (charTaken && txLocal) begin
			if (q_reg.sel[SEL_PRINTER]) begin
				q_next.prtData = txData[q_reg.txSel];
				q_next.prtStb = 1'h1;
			end
			if (q_reg.sel[SEL_PUNCH] && q_reg.punchOn) begin
				q_next.pchData = txData[q_reg.txSel];
				q_next.pchStb = 1'h1;
			end
		end
		// Received data wins over the own echo; in half duplex the two never
		// overlap, so nothing is dropped in normal use.
		if (lineRxStrobe || (charTaken && !txLocal
			&& !q_reg.ctrl[CTRL_FULL_DUPLEX])) begin
			if (!q_reg.sel[SEL_PRINTER]) begin
				q_next.prtData = lineRxStrobe ? rxByte : txData[q_reg.txSel];
				q_next.prtStb = 1'h1;
			end
			if (!q_reg.sel[SEL_PUNCH] && q_reg.punchOn) begin
				q_next.pchData = lineRxStrobe ? rxByte : txData[q_reg.txSel];
				q_next.pchStb = 1'h1;
			end
		end

		if (regWr) begin
			if (regAddr == ADDR_CTRL) begin
				q_next.ctrl = regWdata;
				q_next.punchOn = regWdata[CTRL_PUNCH_EN];
			end else if (regAddr == ADDR_SEL) begin
				q_next.sel = regWdata;
			end
		end
		if (regRd) begin
			if (regAddr == ADDR_CTRL) begin
				q_next.rdata = q_reg.ctrl;
			end else if (regAddr == ADDR_SEL) begin
				q_next.rdata = q_reg.sel;
			end else if (regAddr == ADDR_STAT) begin
				q_next.rdata = stat;
			end else begin
				q_next.rdata = 8'h00;
			end
		end

		if (lineRxStrobe) begin
			if (rxByte == CH_DC1 && q_reg.ctrl[CTRL_READER_AUTO]) begin
				q_next.readerRun = 1'h1;
			end else if (rxByte == CH_DC3 && q_reg.ctrl[CTRL_READER_AUTO]) begin
				q_next.readerRun = 1'h0;
			end else if (rxByte == CH_DC2) begin
				q_next.punchOn = 1'h1;
			end else if (rxByte == CH_DC4) begin
				q_next.punchOn = 1'h0;
			end else if (rxByte == CH_ACK && clearToSend && !q_reg.intrHalt) begin
				q_next.sendEn = 1'h1;
			end else if (rxByte == CH_EOT) begin
				eotEvt = 1'h1;
			end
		end
		if (sendEnableButton && clearToSend) begin
			q_next.sendEn = 1'h1;
			q_next.intrHalt = 1'h0;
		end

		// Clears come last so that any stop condition beats a set.
		if (!clearToSend || (lineRxStrobe && rxByte == CH_NAK)) begin
			q_next.sendEn = 1'h0;
		end
		if (intrRx) begin
			q_next.sendEn = 1'h0;
			q_next.intrHalt = 1'h1;
		end
		if (eotEvt) begin
			q_next.sendEn = 1'h0;
			q_next.readerRun = 1'h0;
		end

		if (ctsRise && (q_reg.primed || ringInd)) begin
			q_next.abStart = q_reg.ctrl[CTRL_ANSWERBACK];
			q_next.primed = 1'h0;
		end else if (ringInd) begin
			q_next.primed = 1'h1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q_reg <= '0;
			q_reg.st <= S_IDLE;
			q_reg.ctrl <= CTRL_RESET;
			q_reg.sel <= SEL_RESET;
			q_reg.ctsPrev <= 1'h1;
		end else begin
			q_reg <= q_next;
		end
	end

	assign tmrIf.start = eotEvt;
	// The call is refused by keeping DTR off while the printer is local.
	assign dataTermReady = !alarm && !q_reg.ctrl[CTRL_NO_ANSWER]
		&& !q_reg.sel[SEL_PRINTER] && !tmrIf.busy;
	assign requestToSend = 1'h1;
	assign sendMsg[0] = (q_reg.st != S_IDLE) && !q_reg.txSel;
	assign sendMsg[1] = (q_reg.st != S_IDLE) && q_reg.txSel;
	assign presentChar[0] = (q_reg.st == S_PRESENT) && !q_reg.txSel;
	assign presentChar[1] = (q_reg.st == S_PRESENT) && q_reg.txSel;
	assign regRdata = q_reg.rdata;
	assign locTxData = q_reg.locData;
	assign locTxStrobe = q_reg.locStb;
	assign lineTxData = q_reg.lineData;
	assign lineTxStrobe = q_reg.lineStb;
	assign printerData = q_reg.prtData;
	assign printerStrobe = q_reg.prtStb;
	assign punchData = q_reg.pchData;
	assign punchStrobe = q_reg.pchStb;
	assign readerRun = q_reg.readerRun;
	assign tapePunchEnable = q_reg.punchOn;
	assign answerBackStart = q_reg.abStart;
	assign sendEnableLamp = q_reg.sendEn;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_one_grant;
		$rose(|sendMsg) |-> $past(q_reg.st) == S_IDLE && !(&sendMsg);
	endproperty
	a_one_grant: assert property (p_one_grant) else $error("double grant");

	property p_present;
		$rose(|presentChar) |-> $past(presentOk);
	endproperty
	a_present: assert property (p_present) else $error("early present");

	property p_serialize;
		charTaken && txLocal |=> locTxStrobe
			&& locTxData == $past(txData[q_reg.txSel]);
	endproperty
	a_serialize: assert property (p_serialize) else $error("char lost");

	property p_punch_gate;
		punchStrobe |-> $past(q_reg.punchOn);
	endproperty
	a_punch_gate: assert property (p_punch_gate) else $error("punch off");

	property p_reader_on;
		lineRxStrobe && rxByte == CH_DC1 && q_reg.ctrl[CTRL_READER_AUTO]
			&& !intrRx |=> readerRun;
	endproperty
	a_reader_on: assert property (p_reader_on) else $error("DC1 missed");

	property p_punch_off;
		lineRxStrobe && rxByte == CH_DC4 && !regWr |=> !tapePunchEnable;
	endproperty
	a_punch_off: assert property (p_punch_off) else $error("DC4 missed");

	property p_cts_drop;
		!clearToSend |=> !sendEnableLamp;
	endproperty
	a_cts_drop: assert property (p_cts_drop) else $error("lamp on");

	property p_intr_hold;
		q_reg.intrHalt && !sendEnableButton |=> !sendEnableLamp;
	endproperty
	a_intr_hold: assert property (p_intr_hold) else $error("ACK after intr");

	property p_eot_dtr;
		lineRxStrobe && rxByte == CH_EOT |=> !dataTermReady [*2];
	endproperty
	a_eot_dtr: assert property (p_eot_dtr) else $error("no DTR drop");

	property p_answerback;
		ctsRise && q_reg.primed && q_reg.ctrl[CTRL_ANSWERBACK]
			|=> answerBackStart ##1 !answerBackStart;
	endproperty
	a_answerback: assert property (p_answerback) else $error("no ab");

	c_local_char: cover property (charTaken && txLocal);
	c_ack_enable: cover property (lineRxStrobe && rxByte == CH_ACK ##1 sendEnableLamp);
	c_eot: cover property (eotEvt);
	c_answerback: cover property (answerBackStart);

endmodule
`default_nettype wire

// file: bench/tsl_dataset_model.sv
`timescale 1ns/1ps
`default_nettype none
// Data set on the far side of the modem leads; it never answers early.
module tsl_dataset_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic dtr,
	input wire logic callReq,
	output logic ring,
	output logic dsr,
	output logic cts
);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ring <= 1'b0;
			dsr <= 1'b0;
			cts <= 1'b0;
		end else if (dsr && !dtr) begin
			dsr <= 1'b0;
			cts <= 1'b0;
		end else if (callReq && dtr) begin
			ring <= 1'b1;
		end else if (ring && dtr) begin
			dsr <= 1'b1;
			cts <= dsr;
			ring <= !dsr;
		end
	end
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
	import tsl_pkg::*;
;
	logic clk, nrst, regWr, regRd, tabBusy, lineRxStrobe, callReq;
	logic sendEnableButton, intrRx, alarm, ringInd, dataSetReady;
	logic clearToSend, dataTermReady, requestToSend, answerBackStart;
	logic sendEnableLamp, locTxStrobe, lineTxStrobe, printerStrobe;
	logic punchStrobe, readerRun, tapePunchEnable;
	logic locDistReady, lineDistReady;
	logic [3:0] regAddr;
	logic [7:0] regWdata, regRdata, lineRxData, locTxData, lineTxData;
	logic [7:0] printerData, punchData;
	logic [1:0] msgAvail, sendReady, charAvail, sendMsg, presentChar;
	logic [1:0][7:0] txData;
	logic [6:0] sigs;
	int mismatches, checked;

	assign sigs = {answerBackStart, lineTxStrobe, locTxStrobe,
		presentChar, sendMsg};

	tsl_send_line #(.DTR_OFF_LEN(8)) DUT (.clk, .nrst, .regAddr,
		.regWdata, .regWr, .regRd, .regRdata, .msgAvail, .sendReady,
		.charAvail, .txData, .sendMsg, .presentChar, .tabBusy,
		.locDistReady, .lineDistReady, .locTxData,
		.locTxStrobe, .lineTxData, .lineTxStrobe, .lineRxData,
		.lineRxStrobe, .printerData, .printerStrobe, .punchData,
		.punchStrobe, .readerRun, .tapePunchEnable, .sendEnableButton,
		.intrRx, .alarm, .ringInd, .dataSetReady, .clearToSend,
		.dataTermReady, .requestToSend, .answerBackStart, .sendEnableLamp);

	tsl_dataset_model partner (.clk, .nrst, .dtr(dataTermReady),
		.callReq, .ring(ringInd), .dsr(dataSetReady), .cts(clearToSend));

	task automatic print_verdict;
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Every wait is bounded so a dead handshake ends the run.
	task automatic waitFor(input int w);
		int n;
		n = 0;
		while (sigs[w] !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 40) begin
				mismatches++;
				$display("[FAIL] %0t wait %h exp %h", $time, w, 1);
				print_verdict();
			end
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		chk(regRdata, exp);
	endtask

	task automatic rx(input logic [7:0] ch);
		@(posedge clk);
		lineRxData <= ch;
		lineRxStrobe <= 1'b1;
		@(posedge clk);
		lineRxStrobe <= 1'b0;
		#1;
	endtask

	task automatic pulse(input bit intr);
		@(posedge clk);
		if (intr)
			intrRx <= 1'b1;
		else
			sendEnableButton <= 1'b1;
		@(posedge clk);
		intrRx <= 1'b0;
		sendEnableButton <= 1'b0;
		#1;
	endtask

	task automatic send_char(input int i, input logic [7:0] ch, input bit loc,
		input bit echo);
		@(posedge clk);
		msgAvail[i] <= 1'b1;
		waitFor(i);
		chk({6'h00, sendMsg}, (i == 1) ? 8'h02 : 8'h01);
		@(posedge clk);
		sendReady[i] <= 1'b1;
		tabBusy <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk({6'h00, presentChar}, 8'h00);
		@(posedge clk);
		tabBusy <= 1'b0;
		if (loc)
			locDistReady <= 1'b0;
		else
			lineDistReady <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk({6'h00, presentChar}, 8'h00);
		@(posedge clk);
		locDistReady <= 1'b1;
		lineDistReady <= 1'b1;
		waitFor(2 + i);
		@(posedge clk);
		txData[i] <= ch;
		charAvail[i] <= 1'b1;
		@(posedge clk);
		charAvail[i] <= 1'b0;
		sendReady[i] <= 1'b0;
		msgAvail[i] <= 1'b0;
		#1 chk(loc ? locTxStrobe : lineTxStrobe, 8'h01);
		chk(loc ? locTxData : lineTxData, ch);
		chk(printerStrobe, {7'h00, echo});
		if (echo)
			chk(printerData, ch);
	endtask

	task automatic t_reset;
		chk(sendEnableLamp, 8'h00);
		chk(requestToSend, 8'h01);
		chk(dataTermReady, 8'h01);
		rd(ADDR_STAT, 8'h20);
		rd(4'hF, 8'h00);
		@(posedge clk);
		alarm <= 1'b1;
		#1 chk(dataTermReady, 8'h00);
		@(posedge clk);
		alarm <= 1'b0;
		wr(ADDR_CTRL, 8'h04);
		chk(dataTermReady, 8'h00);
		wr(ADDR_CTRL, 8'h00);
	endtask

	task automatic t_local;
		wr(ADDR_SEL, 8'h05);
		chk(dataTermReady, 8'h00);
		@(posedge clk);
		msgAvail[1] <= 1'b1;
		send_char(0, 8'h41, 1'b1, 1'b1);
		@(posedge clk);
		msgAvail[1] <= 1'b0;
		wr(ADDR_SEL, 8'h00);
	endtask

	task automatic t_call;
		wr(ADDR_CTRL, 8'h18);
		@(posedge clk);
		callReq <= 1'b1;
		@(posedge clk);
		callReq <= 1'b0;
		waitFor(6);
		chk(clearToSend, 8'h01);
		@(posedge clk);
		#1 chk(answerBackStart, 8'h00);
	endtask

	task automatic t_enable;
		chk(sendEnableLamp, 8'h00);
		rx(CH_ACK);
		chk(sendEnableLamp, 8'h01);
		rx(CH_NAK);
		chk(sendEnableLamp, 8'h00);
		pulse(1'b0);
		chk(sendEnableLamp, 8'h01);
		pulse(1'b1);
		chk(sendEnableLamp, 8'h00);
		rx(CH_ACK);
		chk(sendEnableLamp, 8'h00);
		@(posedge clk);
		msgAvail[0] <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk({6'h00, sendMsg}, 8'h00);
		@(posedge clk);
		msgAvail[0] <= 1'b0;
		pulse(1'b0);
		chk(sendEnableLamp, 8'h01);
	endtask

	task automatic t_codes;
		rx(CH_DC1);
		chk(readerRun, 8'h00);
		wr(ADDR_CTRL, 8'h19);
		rx(CH_DC1);
		chk(readerRun, 8'h01);
		rx(CH_DC3);
		chk(readerRun, 8'h00);
		rx(CH_DC4);
		chk(tapePunchEnable, 8'h00);
		rx(8'h41);
		chk(punchStrobe, 8'h00);
		chk(printerData, 8'h41);
		rx(CH_DC2);
		chk(tapePunchEnable, 8'h01);
		rx(8'h42);
		chk(punchStrobe, 8'h01);
		chk(punchData, 8'h42);
	endtask

	task automatic t_online;
		wr(ADDR_SEL, 8'h08);
		chk(dataTermReady, 8'h01);
		send_char(0, 8'h48, 1'b0, 1'b1);
		wr(ADDR_CTRL, 8'h1B);
		rx(CH_DC1);
		send_char(1, 8'h52, 1'b0, 1'b0);
	endtask

	task automatic t_eot;
		int n;
		n = 0;
		rx(CH_EOT);
		while (dataTermReady !== 1'b1 && n < 50) begin
			n++;
			@(posedge clk);
			#1;
		end
		chk(n[7:0], 8'h08);
		chk(sendEnableLamp, 8'h00);
		chk(readerRun, 8'h00);
		chk(dataSetReady, 8'h00);
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		nrst = 1'b0;
		{regWr, regRd, tabBusy, lineRxStrobe, callReq} = 5'h00;
		{sendEnableButton, intrRx, alarm} = 3'h0;
		regAddr = 4'h0;
		regWdata = 8'h00;
		lineRxData = 8'h00;
		{msgAvail, sendReady, charAvail} = 6'h00;
		{locDistReady, lineDistReady} = 2'h3;
		txData = 16'h0000;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		t_local();
		t_call();
		t_enable();
		t_codes();
		t_online();
		t_eot();
		print_verdict();
	end
endmodule
`default_nettype wire
